// file: mbfhp_device.sv
// Flash end of the muxed burst port: burst and async reads, programming.
// Assumes every pin is asynchronous to mclk and is synchronised here.
// Flash clock edges must be at least three mclk cycles apart.

// What this block does
// - First clock rise with address valid starts burst
// - Rises after the latency advance burst address by one word
// - Host keeps flash clock low in async access
// - Address valid low marks a valid address
// - Address ignored while address valid high; bus then read only as write data
// - Ready low while burst word not valid
// - Reset pin low returns to array read
// - Accelerate high voltage: fast programming, unlock bypass
// - Accelerate low refuses program
// - Host keeps accelerate high otherwise
// - Output enable acts without the flash clock
// - Low address shares the sixteen data lines
// - Host sizes upper address to the die
module mbfhp_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Flash pins
    mbfhp_if.device pins,
    // Array preload
    input wire logic loadValid,
    input wire logic [mbfhp_pkg::MEM_AW-1:0] loadAddr,
    input wire logic [mbfhp_pkg::DATA_W-1:0] loadData,
    // Status
    output logic busyOut,
    output logic bypassMode,
    output logic refusedPulse,
    output logic arrayReading
);

    typedef enum logic [1:0] {
        DEV_IDLE = 2'h0,
        DEV_LATENCY = 2'h1,
        DEV_BURST = 2'h2,
        DEV_PROGRAM = 2'h3
    } mbfhp_dev_state_type;

    mbfhp_dev_state_type state_q;
    logic [mbfhp_pkg::PIN_W-1:0] pinRaw;
    logic [mbfhp_pkg::PIN_W-1:0] pinMeta_q;
    logic [mbfhp_pkg::PIN_W-1:0] pinSync_q;
    logic clkS;
    logic ceS;
    logic oeS;
    logic weS;
    logic avdS;
    logic rstS;
    logic [1:0] accS;
    logic [mbfhp_pkg::UPPER_W-1:0] upperS;
    logic [mbfhp_pkg::DATA_W-1:0] busS;
    logic clkPrev_q;
    logic wePrev_q;
    logic clkRise;
    logic weRise;
    logic startBurst;
    logic [mbfhp_pkg::ADDR_W-1:0] addr_q;
    logic [7:0] latCnt_q;
    logic [7:0] progCnt_q;
    logic [mbfhp_pkg::DATA_W-1:0] progData_q;
    logic progCommit;
    logic [mbfhp_pkg::DATA_W-1:0] mem [mbfhp_pkg::MEM_DEPTH];
    logic [mbfhp_pkg::DATA_W-1:0] dataOut_q;
    logic bypass_q;
    logic refused_q;

    // Two-flop capture of every pin
    assign pinRaw = {pins.flashClk, pins.chipEn_n, pins.outEn_n, pins.writeEn_n, pins.addr_valid_n,
                     pins.flashRst_n, pins.program_accel_in, pins.upperAddr, pins.shared_addr_data_bus};

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_q <= mbfhp_pkg::PIN_RESET;
            pinSync_q <= mbfhp_pkg::PIN_RESET;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end

    assign {clkS, ceS, oeS, weS, avdS, rstS, accS, upperS, busS} = pinSync_q;

    // Edge memory, taken from the second stage only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clkPrev_q <= 1'b0;
            wePrev_q <= 1'b1;
        end else begin
            clkPrev_q <= clkS;
            wePrev_q <= weS;
        end
    end

    assign clkRise = clkS & ~clkPrev_q;
    assign weRise = weS & ~wePrev_q;
    // A rise with the chip selected and address valid low opens a burst
    assign startBurst = clkRise & ~avdS & ~ceS & rstS & (state_q != DEV_PROGRAM);
    assign progCommit = (state_q == DEV_PROGRAM) && (progCnt_q == 8'h01);

    // Sequencing of reads and programming
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= DEV_IDLE;
            addr_q <= '0;
            latCnt_q <= 8'h00;
            progCnt_q <= 8'h00;
            progData_q <= '0;
        end else if (!rstS) begin
            // Abandons any burst or program in flight
            state_q <= DEV_IDLE;
            addr_q <= '0;
            latCnt_q <= 8'h00;
            progCnt_q <= 8'h00;
        end else if (startBurst) begin
            // Low half comes off the shared lines
            addr_q <= {upperS, busS};
            latCnt_q <= mbfhp_pkg::BURST_LAT_EDGES;
            state_q <= DEV_LATENCY;
        end else begin
            case (state_q)
                DEV_IDLE: begin
                    if (!ceS && !avdS && !clkS) begin
                        // Transparent latch while address valid is low
                        addr_q <= {upperS, busS};
                    end else if (!ceS && weRise && avdS && accS != mbfhp_pkg::ACC_LOW) begin
                        progData_q <= busS;
                        progCnt_q <= bypass_q ? mbfhp_pkg::PROG_FAST_CYC : mbfhp_pkg::PROG_CYC;
                        state_q <= DEV_PROGRAM;
                    end
                end
                DEV_LATENCY: begin
                    if (ceS) begin
                        state_q <= DEV_IDLE;
                    end else if (clkRise) begin
                        if (latCnt_q == 8'h01) begin
                            state_q <= DEV_BURST;
                        end
                        latCnt_q <= latCnt_q - 8'h01;
                    end
                end
                DEV_BURST: begin
                    if (ceS) begin
                        state_q <= DEV_IDLE;
                    end else if (clkRise) begin
                        addr_q <= addr_q + mbfhp_pkg::ADDR_W'(1);
                    end
                end
                DEV_PROGRAM: begin
                    if (progCommit) begin
                        state_q <= DEV_IDLE;
                    end
                    progCnt_q <= progCnt_q - 8'h01;
                end
                default: begin
                    state_q <= DEV_IDLE;
                end
            endcase
        end
    end

    // Write with accelerate low is dropped and flagged
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            refused_q <= 1'b0;
        end else begin
            refused_q <= rstS && state_q == DEV_IDLE && !ceS && weRise && avdS
                         && accS == mbfhp_pkg::ACC_LOW;
        end
    end

    // Unlock bypass follows the high voltage level itself
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bypass_q <= 1'b0;
        end else begin
            bypass_q <= rstS && accS == mbfhp_pkg::ACC_VHH;
        end
    end

    // Array; programming can only clear bits, as in real flash cells
    always_ff @(posedge mclk) begin
        if (progCommit && rstS) begin
            mem[addr_q[mbfhp_pkg::MEM_AW-1:0]] <= mem[addr_q[mbfhp_pkg::MEM_AW-1:0]] & progData_q;
        end else if (loadValid) begin
            mem[loadAddr] <= loadData;
        end
    end

    // Output word follows the address one cycle later
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dataOut_q <= '0;
        end else begin
            dataOut_q <= mem[addr_q[mbfhp_pkg::MEM_AW-1:0]];
        end
    end

    assign pins.devBusOut = dataOut_q;
    // Output enable gated by level only, never by the flash clock
    assign pins.devBusOe = ~ceS & ~oeS & avdS & weS & (state_q != DEV_PROGRAM);
    // Low only while the first burst word is still on its way
    assign pins.flashReady = (state_q != DEV_LATENCY);

    assign busyOut = (state_q == DEV_PROGRAM);
    assign bypassMode = bypass_q;
    assign refusedPulse = refused_q;
    assign arrayReading = (state_q != DEV_PROGRAM) & rstS;

endmodule

// file: mbfhp_host.sv
// Controller end of the muxed burst port and its read-data FIFO.
// Assumes the flash end answers within the waits set in the package.
// Read words pass through a small FIFO; a full FIFO stops the flash clock.

module mbfhp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign inReady = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = store[rdPtr_q];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_ff @(posedge mclk) begin
        if (push) begin
            store[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule

module mbfhp_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Flash pins
    mbfhp_if.host pins,
    // Requests
    input wire logic reqValid,
    output logic reqReady,
    input wire mbfhp_pkg::mbfhp_op_type reqOp,
    input wire logic [mbfhp_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [mbfhp_pkg::DATA_W-1:0] reqData,
    input wire logic [7:0] reqLen,
    // Pin control
    input wire logic [1:0] accelSelect,
    input wire logic resetReq,
    // Read data
    output logic rspValid,
    input wire logic rspReady,
    output logic [mbfhp_pkg::DATA_W-1:0] rspData,
    // Status
    output logic writeDone
);

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_ADDR = 3'h1,
        H_ASYNC_WAIT = 3'h2,
        H_WRITE = 3'h3,
        H_BURST = 3'h4,
        H_RESET = 3'h5,
        H_END = 3'h6
    } mbfhp_host_state_type;

    mbfhp_host_state_type state_q;
    mbfhp_pkg::mbfhp_op_type op_q;
    logic [mbfhp_pkg::ADDR_W-1:0] addr_q;
    logic [mbfhp_pkg::DATA_W-1:0] wdata_q;
    logic [7:0] len_q;
    logic [7:0] cnt_q;
    logic [7:0] timer_q;
    logic [7:0] div_q;
    logic clk_q;
    logic ce_n_q;
    logic oe_n_q;
    logic we_n_q;
    logic avd_n_q;
    logic rst_n_q;
    logic busOe_q;
    logic [mbfhp_pkg::DATA_W-1:0] busOut_q;
    logic [1:0] acc_q;
    logic writeDone_q;
    logic [mbfhp_pkg::DATA_W:0] inMeta_q;
    logic [mbfhp_pkg::DATA_W:0] inSync_q;
    logic readyS;
    logic [mbfhp_pkg::DATA_W-1:0] busS;
    logic clocked;
    logic riseAllowed;
    logic clkRiseNow;
    logic clkFallNow;
    logic fifoInValid;
    logic fifoInReady;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            inMeta_q <= mbfhp_pkg::HOST_SYNC_RESET;
            inSync_q <= mbfhp_pkg::HOST_SYNC_RESET;
        end else begin
            inMeta_q <= {pins.flashReady, pins.shared_addr_data_bus};
            inSync_q <= inMeta_q;
        end
    end
    assign {readyS, busS} = inSync_q;

    // Flash clock runs only in burst phases, low otherwise
    assign clocked = (state_q == H_BURST) || (state_q == H_ADDR && op_q == mbfhp_pkg::OP_BURST_READ);
    // Each rise after the opening one may yield a word, so it waits for FIFO room
    assign riseAllowed = (state_q == H_ADDR) || fifoInReady;
    assign clkRiseNow = clocked && div_q == mbfhp_pkg::HALF_CLK_CYC - 8'h01 && !clk_q && riseAllowed;
    assign clkFallNow = clocked && div_q == mbfhp_pkg::HALF_CLK_CYC - 8'h01 && clk_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_q <= 1'b0;
            div_q <= 8'h00;
        end else if (!clocked) begin
            clk_q <= 1'b0;
            div_q <= 8'h00;
        end else begin
            div_q <= (div_q == mbfhp_pkg::HALF_CLK_CYC - 8'h01) ? 8'h00 : div_q + 8'h01;
            if (clkRiseNow || clkFallNow) begin
                clk_q <= ~clk_q;
            end
        end
    end

    // Accelerate stays at the normal level unless the user picks otherwise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= mbfhp_pkg::ACC_HIGH;
        end else begin
            acc_q <= accelSelect;
        end
    end

    // Burst words only count on rises where ready was seen high
    assign fifoInValid = (state_q == H_BURST && clkRiseNow && readyS)
                         || (state_q == H_ASYNC_WAIT && timer_q == 8'h00);
    assign reqReady = (state_q == H_IDLE) && !resetReq;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            op_q <= mbfhp_pkg::OP_ASYNC_READ;
            addr_q <= '0;
            wdata_q <= '0;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            timer_q <= 8'h00;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            avd_n_q <= 1'b1;
            rst_n_q <= 1'b1;
            busOe_q <= 1'b0;
            busOut_q <= '0;
            writeDone_q <= 1'b0;
        end else begin
            writeDone_q <= 1'b0;
            if (timer_q != 8'h00) begin
                timer_q <= timer_q - 8'h01;
            end
            case (state_q)
                H_IDLE: begin
                    if (resetReq) begin
                        rst_n_q <= 1'b0;
                        timer_q <= mbfhp_pkg::RST_CYC - 8'h01;
                        state_q <= H_RESET;
                    end else if (reqValid) begin
                        op_q <= reqOp;
                        addr_q <= reqAddr;
                        wdata_q <= reqData;
                        len_q <= reqLen;
                        cnt_q <= 8'h00;
                        ce_n_q <= 1'b0;
                        avd_n_q <= 1'b0;
                        busOe_q <= 1'b1;
                        busOut_q <= reqAddr[mbfhp_pkg::LOW_ADDR_W-1:0];
                        timer_q <= mbfhp_pkg::AVD_CYC - 8'h01;
                        state_q <= H_ADDR;
                    end
                end
                H_ADDR: begin
                    if (op_q == mbfhp_pkg::OP_BURST_READ) begin
                        if (clkRiseNow) begin
                            state_q <= H_BURST;
                        end
                    end else if (timer_q == 8'h00) begin
                        avd_n_q <= 1'b1;
                        if (op_q == mbfhp_pkg::OP_WRITE) begin
                            busOut_q <= wdata_q;
                            we_n_q <= 1'b0;
                            timer_q <= mbfhp_pkg::WE_CYC - 8'h01;
                            state_q <= H_WRITE;
                        end else begin
                            busOe_q <= 1'b0;
                            oe_n_q <= 1'b0;
                            timer_q <= mbfhp_pkg::READ_CYC - 8'h01;
                            state_q <= H_ASYNC_WAIT;
                        end
                    end
                end
                H_ASYNC_WAIT: begin
                    if (timer_q == 8'h00 && fifoInReady) begin
                        timer_q <= mbfhp_pkg::GAP_CYC - 8'h01;
                        state_q <= H_END;
                    end
                end
                H_WRITE: begin
                    if (timer_q == 8'h00) begin
                        // Data and select held past the write strobe rise
                        we_n_q <= 1'b1;
                        writeDone_q <= 1'b1;
                        timer_q <= mbfhp_pkg::GAP_CYC - 8'h01;
                        state_q <= H_END;
                    end
                end
                H_BURST: begin
                    // Address stays valid through the opening rise, freed at the fall
                    if (clkFallNow) begin
                        avd_n_q <= 1'b1;
                        busOe_q <= 1'b0;
                        oe_n_q <= 1'b0;
                    end
                    if (fifoInValid) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q + 8'h01 == len_q) begin
                            timer_q <= mbfhp_pkg::GAP_CYC - 8'h01;
                            state_q <= H_END;
                        end
                    end
                end
                H_END: begin
                    if (timer_q == 8'h00) begin
                        ce_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        avd_n_q <= 1'b1;
                        busOe_q <= 1'b0;
                        state_q <= H_IDLE;
                    end
                end
                H_RESET: begin
                    if (timer_q == 8'h00) begin
                        rst_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    assign pins.flashClk = clk_q;
    assign pins.chipEn_n = ce_n_q;
    assign pins.outEn_n = oe_n_q;
    assign pins.writeEn_n = we_n_q;
    assign pins.addr_valid_n = avd_n_q;
    assign pins.flashRst_n = rst_n_q;
    assign pins.program_accel_in = acc_q;
    assign pins.upperAddr = addr_q[mbfhp_pkg::ADDR_W-1:mbfhp_pkg::LOW_ADDR_W];
    assign pins.hostBusOut = busOut_q;
    assign pins.hostBusOe = busOe_q;
    assign writeDone = writeDone_q;

    mbfhp_fifo #(
        .WIDTH(mbfhp_pkg::DATA_W),
        .DEPTH(mbfhp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(busS),
        .outValid(rspValid),
        .outReady(rspReady),
        .outData(rspData)
    );

endmodule

// file: mbfhp_if.sv
// Flash pin bundle between the controller end and the flash end.
// Assumes at most one end enables the shared bus at a time.
interface mbfhp_if;
    logic flashClk;
    logic chipEn_n;
    logic outEn_n;
    logic writeEn_n;
    logic addr_valid_n;
    logic flashRst_n;
    logic [1:0] program_accel_in;
    logic [mbfhp_pkg::UPPER_W-1:0] upperAddr;
    logic [mbfhp_pkg::DATA_W-1:0] hostBusOut;
    logic hostBusOe;
    logic [mbfhp_pkg::DATA_W-1:0] devBusOut;
    logic devBusOe;
    logic [mbfhp_pkg::DATA_W-1:0] shared_addr_data_bus;
    logic flashReady;

    // Undriven bus reads as zero
    assign shared_addr_data_bus = hostBusOe ? hostBusOut : (devBusOe ? devBusOut : '0);

    modport host (
        output flashClk, chipEn_n, outEn_n, writeEn_n, addr_valid_n, flashRst_n,
        output program_accel_in, upperAddr, hostBusOut, hostBusOe,
        input shared_addr_data_bus, flashReady
    );

    modport device (
        input flashClk, chipEn_n, outEn_n, writeEn_n, addr_valid_n, flashRst_n,
        input program_accel_in, upperAddr, shared_addr_data_bus,
        output devBusOut, devBusOe, flashReady
    );
endinterface

// file: mbfhp_pkg.sv
// Shared constants and types for the muxed burst flash port.
// Assumes a single 50 MHz system clock on both ends.
package mbfhp_pkg;

    // Bus geometry; top address bit is A25 for the largest die
    localparam int DATA_W = 16;
    localparam int ADDR_W = 26;
    localparam int LOW_ADDR_W = 16;
    localparam int UPPER_W = ADDR_W - LOW_ADDR_W;

    // Modelled array, low address bits only
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;

    // Burst latency in flash clock rising edges
    localparam logic [7:0] BURST_LAT_EDGES = 8'h02;
    // Flash clock half period in system cycles
    localparam logic [7:0] HALF_CLK_CYC = 8'h04;
    localparam int FIFO_DEPTH = 4;

    // Timing figures
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 400;
    localparam int PROG_FAST_NS = 100;
    localparam int AVD_PULSE_NS = 60;
    localparam int READ_WAIT_NS = 160;
    localparam int WE_PULSE_NS = 120;
    localparam int RST_PULSE_NS = 200;
    localparam int GAP_NS = 80;
    localparam logic [7:0] PROG_CYC = 8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] PROG_FAST_CYC = 8'((PROG_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] AVD_CYC = 8'((AVD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_CYC = 8'((READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WE_CYC = 8'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RST_CYC = 8'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] GAP_CYC = 8'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Accelerate pin levels
    localparam logic [1:0] ACC_LOW = 2'h0;
    localparam logic [1:0] ACC_HIGH = 2'h1;
    localparam logic [1:0] ACC_VHH = 2'h2;

    // Device pin capture: clk, ce, oe, we, avd, rst, acc, upper, bus
    localparam int PIN_W = 8 + UPPER_W + DATA_W;
    localparam logic [PIN_W-1:0] PIN_RESET = {1'h0, 5'h1f, ACC_HIGH, {UPPER_W{1'b0}}, {DATA_W{1'b0}}};
    localparam logic [DATA_W:0] HOST_SYNC_RESET = {1'h0, {DATA_W{1'b0}}};

    typedef enum logic [1:0] {
        OP_ASYNC_READ = 2'h0,
        OP_BURST_READ = 2'h1,
        OP_WRITE = 2'h2
    } mbfhp_op_type;

endpackage

// file: mbfhp_props.sv
// Pin checks between the host and flash ends.
// Assumes one clock and one reset for both ends.
module mbfhp_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Flash pins
    input wire logic flashClk,
    input wire logic chipEn_n,
    input wire logic outEn_n,
    input wire logic writeEn_n,
    input wire logic addr_valid_n,
    input wire logic flashRst_n,
    input wire logic hostBusOe,
    input wire logic devBusOe,
    input wire logic flashReady
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    a_bus_no_clash: assert property (!(hostBusOe && devBusOe)) else $error("bus clash");
    a_avd_drives_addr: assert property (!addr_valid_n |-> hostBusOe) else $error("addr not driven");
    a_oe_bus_free: assert property (!outEn_n |-> !hostBusOe) else $error("host holds bus");
    a_clk_idle_low: assert property (chipEn_n |-> !flashClk) else $error("clock outside op");
    a_write_clk_low: assert property (!writeEn_n |-> !flashClk && !chipEn_n) else $error("clock in write");
    a_ready_idle_high: assert property (chipEn_n [*4] |-> flashReady) else $error("ready low in idle");
    a_burst_latency: assert property ($rose(flashClk) && !addr_valid_n |-> ##[1:6] !flashReady)
        else $error("no burst latency");
    a_reset_quiet: assert property (!flashRst_n [*4] |-> !devBusOe) else $error("drive in reset");
    // Cheap hints that the main scenarios ran
    c_burst: cover property ($rose(flashClk) && !addr_valid_n);
    c_write: cover property ($fell(writeEn_n));
    c_pin_reset: cover property ($fell(flashRst_n));
endmodule

// file: tb_muxed_burst_flash_host_port.sv
// Bench joining the host and flash ends over the pin bundle.
// Assumes package, interface, both ends and checker compiled first.
module tb_muxed_burst_flash_host_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst = 1, loadValid = 0, reqValid = 0, rspReady = 0, resetReq = 0, hold = 0;
    logic refSeen, bypSeen, rstSeen, reqReady, rspValid, busyOut, bypassMode, refusedPulse, arrayReading;
    logic wDone, wdSeen;
    logic [7:0] loadAddr = 8'h0, reqLen = 8'h0, a;
    logic [15:0] loadData = 16'h0, reqData = 16'h0, d, rspData, mem [256], expQ [$];
    logic [25:0] reqAddr = 26'h0;
    logic [1:0] accelSelect = 2'h1;
    mbfhp_pkg::mbfhp_op_type reqOp = mbfhp_pkg::OP_ASYNC_READ;
    int errors = 0, samples_checked = 0;
    mbfhp_if u_mbfhp_if ();
    mbfhp_host u_mbfhp_host (.mclk(mclk), .sys_rst(sys_rst), .pins(u_mbfhp_if.host), .reqValid(reqValid),
        .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .reqLen(reqLen),
        .accelSelect(accelSelect), .resetReq(resetReq), .rspValid(rspValid), .rspReady(rspReady),
        .rspData(rspData), .writeDone(wDone));
    mbfhp_device u_mbfhp_device (.mclk(mclk), .sys_rst(sys_rst), .pins(u_mbfhp_if.device), .loadValid(loadValid),
        .loadAddr(loadAddr), .loadData(loadData), .busyOut(busyOut), .bypassMode(bypassMode),
        .refusedPulse(refusedPulse), .arrayReading(arrayReading));
    mbfhp_props u_mbfhp_props (.mclk(mclk), .sys_rst(sys_rst), .flashClk(u_mbfhp_if.flashClk),
        .chipEn_n(u_mbfhp_if.chipEn_n), .outEn_n(u_mbfhp_if.outEn_n), .writeEn_n(u_mbfhp_if.writeEn_n),
        .addr_valid_n(u_mbfhp_if.addr_valid_n), .flashRst_n(u_mbfhp_if.flashRst_n),
        .hostBusOe(u_mbfhp_if.hostBusOe), .devBusOe(u_mbfhp_if.devBusOe), .flashReady(u_mbfhp_if.flashReady));
    initial forever #10 mclk = ~mclk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Upper and middle address bits random: only the low byte selects a word
    task automatic req(input int op, input logic [7:0] ad, input logic [15:0] dt, input logic [7:0] n);
        int i;
        reqValid = 1;
        reqOp = mbfhp_pkg::mbfhp_op_type'(op);
        reqAddr = {18'($urandom), ad};
        reqData = dt;
        reqLen = n;
        @(negedge mclk);
        reqValid = 0;
        for (i = 0; i < 600 && (reqReady !== 1 || busyOut !== 0 || expQ.size() != 0); i++)
            @(negedge mclk);
        // One idle cycle: the flash end frees the bus two cycles after select rises
        @(negedge mclk);
        if (i == 600)
            errors++;
    endtask
    // Held low while the FIFO must fill
    always @(negedge mclk) rspReady <= hold ? 1'b0 : 1'($urandom);
    always @(posedge mclk) begin
        if (rspValid === 1 && rspReady === 1)
            chk(rspData, expQ.size() != 0 ? expQ.pop_front() : 16'hxxxx);
        if (refusedPulse === 1)
            refSeen = 1;
        if (bypassMode === 1)
            bypSeen = 1;
        if (wDone === 1)
            wdSeen = 1;
        if (arrayReading === 0 && busyOut === 0)
            rstSeen = 1;
    end
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(90147));
        repeat (2) @(negedge mclk);
        sys_rst = 0;
        for (int i = 0; i < 256; i++) begin
            loadValid = 1;
            loadAddr = 8'(i);
            loadData = 16'($urandom);
            mem[i] = loadData;
            @(negedge mclk);
        end
        loadValid = 0;
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            expQ.push_back(mem[a]);
            req(0, a, 16'h0, 8'h1);
        end
        $display("async read test done");
        // Start near the top so the array index wraps mid-burst
        hold = 1;
        for (int i = 0; i < 6; i++)
            expQ.push_back(mem[8'hfd + 8'(i)]);
        fork
            req(1, 8'hfd, 16'h0, 8'h6);
            begin
                repeat (150) @(negedge mclk);
                hold = 0;
            end
        join
        $display("burst test done");
        for (int k = 0; k < 3; k++) begin
            accelSelect = 2'(k);
            repeat (4) @(negedge mclk);
            refSeen = 0;
            bypSeen = 0;
            wdSeen = 0;
            a = 8'($urandom);
            d = 16'($urandom);
            req(2, a, d, 8'h1);
            chk(16'(refSeen), 16'(k == 0));
            chk(16'(bypSeen), 16'(k == 2));
            chk(16'(wdSeen), 16'h1);
            if (k != 0)
                mem[a] = mem[a] & d;
            expQ.push_back(mem[a]);
            req(0, a, 16'h0, 8'h1);
        end
        accelSelect = 2'h1;
        $display("program test done");
        rstSeen = 0;
        resetReq = 1;
        @(negedge mclk);
        resetReq = 0;
        repeat (30) @(negedge mclk);
        chk(16'(rstSeen), 16'h1);
        expQ.push_back(mem[a]);
        req(0, a, 16'h0, 8'h1);
        $display("pin reset test done");
        end_of_test();
    end
endmodule
